// File: src/acs_regs.svh
// Field positions, encodings, reset values and cycle counts of the sequencer
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

`define ACS_CFG_W 8
`define ACS_ACQ_LSB 0
`define ACS_ACQ_MSB 1
`define ACS_SYNC_BIT 2
`define ACS_BW_BIT 3
`define ACS_CMD_LSB 4
`define ACS_CMD_MSB 7
`define ACS_CFG_RST 8'h54

`define ACS_CMD_START 4'h1
`define ACS_CMD_CAL 4'h2
`define ACS_CMD_ZERO 4'h3
`define ACS_CMD_ABORT 4'h4
`define ACS_CMD_STANDBY 4'h5

`define ACS_ACQ_SEL0 16'h0009
`define ACS_ACQ_SEL1 16'h000f
`define ACS_ACQ_SEL2 16'h002f
`define ACS_ACQ_SEL3 16'h004f
`define ACS_CONV_CYC 44
`define ACS_CAL_CYC 4000
`define ACS_ZERO_CYC 80

`define ACS_RES_W 13
`define ACS_PIN_W 18
`define ACS_PIN_WR 0
`define ACS_PIN_RD 1
`define ACS_PIN_CS 2
`define ACS_PIN_TRIG 3
`define ACS_PIN_STRAP 4
`define ACS_PIN_DATA 5
`define ACS_PIN_RST 18'h00007

`endif

// File: src/acs_pkg.sv
// Types shared by the sequencer modules
package acs_pkg;
  typedef enum logic [2:0] {
    ACS_ST_STBY,
    ACS_ST_IDLE,
    ACS_ST_CAL,
    ACS_ST_ZERO,
    ACS_ST_ACQ,
    ACS_ST_ARMED,
    ACS_ST_CONV
  } acs_state_t;
endpackage

// File: src/acs_pin_if.sv
// Filtered pin levels passed from the synchroniser to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface acs_pin_if #(parameter int W = 18);
  logic [W-1:0] lvl;
  logic [W-1:0] prv;
  modport src (output lvl, output prv);
  modport dst (input lvl, input prv);
endinterface
`default_nettype wire

// File: src/acs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module acs_pin_sync #(
  parameter int W = 18,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i, // Converter clock
  input wire logic rst_i, // Sync reset, high
  input wire logic [W-1:0] pins_i, // Raw pins
  acs_pin_if.src pins // Filtered levels
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, prv_q;
  logic [W-1:0] s1_d, s2_d, s3_d, lvl_d, prv_d;

  always_comb begin
    s1_d = pins_i;
    s2_d = s1_q;
    s3_d = s2_q;
    prv_d = lvl_q;
    lvl_d = lvl_q;
    for (int i = 0; i < W; i++) begin
      // A change counts once stages two and three agree
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
      prv_q <= RST_VAL;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
      prv_q <= prv_d;
    end
  end

  assign pins.lvl = lvl_q;
  assign pins.prv = prv_q;
endmodule
`default_nettype wire

// File: src/acs_seq.sv
// Command and conversion sequencer of a sampling converter
//
// How it works
// - Cal/zero write raises ready, falls when done
// - 8-bit self-timed: second read starts acquisition
// - Trigger pin driven high after acquisition
// - Conversion end drops ready and trigger
// - 8-bit reads: low byte then high
// - Second read restarts when start held
// - 13-bit read returns all, starts acquisition
// - New config accepted on any write, even mid-conversion
// - External mode ignores acquisition select
// - External 8-bit: trigger or second read
// - External 13-bit: trigger or read raises ready
// - Only trigger rise starts external conversion
// - External acquisition lasts until trigger rise
// - Abort cancels work, drives ready low
// - Abort leaves standby
// - Standby at reset; other command exits
// - Acquisition of 9, 15, 47, 79 cycles
// - Strap picks write strobe edge
// - Bus width is 8 bits after reset
`include "acs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module acs_seq #(
  parameter int CONV_CYC = `ACS_CONV_CYC,
  parameter int CAL_CYC = `ACS_CAL_CYC,
  parameter int ZERO_CYC = `ACS_ZERO_CYC
) (
  input wire logic clk_i, // Converter clock, 100 MHz
  input wire logic rst_i, // Sync reset, high
  input wire logic cs_n_i, // Chip select, low
  input wire logic rd_n_i, // Read strobe, low
  input wire logic wr_n_i, // Write strobe, low
  input wire logic write_edge_strap_i, // 1: latch on falling edge
  input wire logic [12:0] data_i, // Bus data in
  output logic [12:0] data_o, // Bus data out
  output logic data_oe_o, // Bus drive enable
  input wire logic trig_i, // Sample trigger pin in
  output logic trig_o, // Sample trigger pin out
  output logic trig_oe_o, // Sample trigger drive enable
  output logic ready_n_o, // Ready flag, low when ready
  input wire logic [12:0] result_i // Converter core result
);
  acs_pin_if #(.W(`ACS_PIN_W)) pins ();

  acs_pin_sync #(.W(`ACS_PIN_W), .RST_VAL(`ACS_PIN_RST)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i({data_i, write_edge_strap_i, trig_i, cs_n_i, rd_n_i, wr_n_i}),
    .pins(pins)
  );

  acs_pkg::acs_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0] cfg_q, cfg_d;
  logic [12:0] res_q, res_d;
  logic [12:0] dout_q, dout_d;
  logic ptr_q, ptr_d;
  logic rdy_q, rdy_d;
  logic trg_q, trg_d;
  logic cs_hold, wr_rise, wr_fall, rd_rise, trig_rise;
  logic wr_evt, rd_evt, read_go, bw, sync_mode, start_held;
  logic [3:0] wcmd;
  logic [7:0] wdata;
  logic [15:0] acq_cyc;

  assign cs_hold = ~pins.prv[`ACS_PIN_CS];
  assign wr_rise = pins.lvl[`ACS_PIN_WR] & ~pins.prv[`ACS_PIN_WR];
  assign wr_fall = ~pins.lvl[`ACS_PIN_WR] & pins.prv[`ACS_PIN_WR];
  assign rd_rise = pins.lvl[`ACS_PIN_RD] & ~pins.prv[`ACS_PIN_RD];
  assign trig_rise = pins.lvl[`ACS_PIN_TRIG] & ~pins.prv[`ACS_PIN_TRIG];
  assign wr_evt = cs_hold & (pins.lvl[`ACS_PIN_STRAP] ? wr_fall : wr_rise);
  assign rd_evt = cs_hold & rd_rise;
  assign wdata = pins.prv[`ACS_PIN_DATA +: 8];
  assign wcmd = wdata[`ACS_CMD_MSB:`ACS_CMD_LSB];
  assign bw = cfg_q[`ACS_BW_BIT];
  assign sync_mode = cfg_q[`ACS_SYNC_BIT];
  assign start_held = cfg_q[`ACS_CMD_MSB:`ACS_CMD_LSB] == `ACS_CMD_START;
  // 13-bit: every read; 8-bit: second of a pair
  assign read_go = rd_evt & (bw | ptr_q);

  always_comb begin
    unique case (cfg_q[`ACS_ACQ_MSB:`ACS_ACQ_LSB])
      2'h0: acq_cyc = `ACS_ACQ_SEL0;
      2'h1: acq_cyc = `ACS_ACQ_SEL1;
      2'h2: acq_cyc = `ACS_ACQ_SEL2;
      2'h3: acq_cyc = `ACS_ACQ_SEL3;
    endcase
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cfg_d = cfg_q;
    res_d = res_q;
    ptr_d = ptr_q;
    if (rd_evt) begin
      ptr_d = ~bw & ~ptr_q;
    end
    if (wr_evt) begin
      cfg_d = wdata;
      ptr_d = 1'b0;
      unique case (wcmd)
        `ACS_CMD_ABORT: state_d = acs_pkg::ACS_ST_IDLE;
        `ACS_CMD_STANDBY: state_d = acs_pkg::ACS_ST_STBY;
        `ACS_CMD_CAL: begin
          state_d = acs_pkg::ACS_ST_CAL;
          cnt_d = 16'(CAL_CYC);
        end
        `ACS_CMD_ZERO: begin
          state_d = acs_pkg::ACS_ST_ZERO;
          cnt_d = 16'(ZERO_CYC);
        end
        default: begin
          if (state_q == acs_pkg::ACS_ST_STBY) begin
            state_d = acs_pkg::ACS_ST_IDLE;
          end
        end
      endcase
    end else begin
      unique case (state_q)
        acs_pkg::ACS_ST_STBY: ;
        acs_pkg::ACS_ST_IDLE: begin
          if (start_held && sync_mode && trig_rise) begin
            state_d = acs_pkg::ACS_ST_CONV;
            cnt_d = 16'(CONV_CYC);
          end else if (start_held && read_go && sync_mode) begin
            state_d = acs_pkg::ACS_ST_ARMED;
          end else if (start_held && read_go) begin
            state_d = acs_pkg::ACS_ST_ACQ;
            cnt_d = acq_cyc;
          end
        end
        acs_pkg::ACS_ST_ARMED: begin
          if (trig_rise) begin
            state_d = acs_pkg::ACS_ST_CONV;
            cnt_d = 16'(CONV_CYC);
          end
        end
        acs_pkg::ACS_ST_ACQ: begin
          cnt_d = cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            state_d = acs_pkg::ACS_ST_CONV;
            cnt_d = 16'(CONV_CYC);
          end
        end
        acs_pkg::ACS_ST_CONV: begin
          cnt_d = cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            state_d = acs_pkg::ACS_ST_IDLE;
            res_d = result_i;
          end
        end
        acs_pkg::ACS_ST_CAL, acs_pkg::ACS_ST_ZERO: begin
          cnt_d = cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            state_d = acs_pkg::ACS_ST_IDLE;
          end
        end
      endcase
    end
    rdy_d = state_d != acs_pkg::ACS_ST_IDLE;
    trg_d = ~cfg_d[`ACS_SYNC_BIT] & (state_d == acs_pkg::ACS_ST_CONV);
    if (bw) begin
      dout_d = res_q;
    end else if (ptr_q) begin
      dout_d = {5'h00, {3{res_q[12]}}, res_q[12:8]};
    end else begin
      dout_d = {5'h00, res_q[7:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= acs_pkg::ACS_ST_STBY;
      cnt_q <= 16'h0000;
      cfg_q <= `ACS_CFG_RST;
      res_q <= 13'h0000;
      dout_q <= 13'h0000;
      ptr_q <= 1'b0;
      rdy_q <= 1'b1;
      trg_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cfg_q <= cfg_d;
      res_q <= res_d;
      dout_q <= dout_d;
      ptr_q <= ptr_d;
      rdy_q <= rdy_d;
      trg_q <= trg_d;
    end
  end

  assign ready_n_o = rdy_q;
  assign trig_o = trg_q;
  assign trig_oe_o = ~sync_mode;
  assign data_o = dout_q;
  assign data_oe_o = ~pins.lvl[`ACS_PIN_CS] & ~pins.lvl[`ACS_PIN_RD];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  cal_start_a: assert property (wr_evt && wcmd == `ACS_CMD_CAL |=>
    ready_n_o && state_q == acs_pkg::ACS_ST_CAL && cnt_q == 16'(CAL_CYC))
    else $error("cal write did not raise ready");
  cal_done_a: assert property ((state_q == acs_pkg::ACS_ST_ZERO ||
    state_q == acs_pkg::ACS_ST_CAL) && cnt_q == 16'h0001 && !wr_evt
    |=> !ready_n_o)
    else $error("ready not low after cal");
  acq_start_a: assert property (state_q == acs_pkg::ACS_ST_IDLE &&
    start_held && !sync_mode && read_go && !wr_evt |=>
    ready_n_o && state_q == acs_pkg::ACS_ST_ACQ && cnt_q == $past(acq_cyc))
    else $error("read did not start acquisition");
  trig_high_a: assert property (state_q == acs_pkg::ACS_ST_ACQ &&
    cnt_q == 16'h0001 && !wr_evt |=> trig_o && trig_oe_o)
    else $error("trigger not high after acquisition");
  conv_end_a: assert property (state_q == acs_pkg::ACS_ST_CONV &&
    cnt_q == 16'h0001 && !wr_evt |=> !ready_n_o && !trig_o)
    else $error("conversion end left ready or trigger high");
  low_byte_a: assert property (!bw && !ptr_q |=>
    data_o == {5'h00, $past(res_q[7:0])})
    else $error("low byte not presented");
  armed_hold_a: assert property (state_q == acs_pkg::ACS_ST_ARMED &&
    !trig_rise && !wr_evt |=> state_q == acs_pkg::ACS_ST_ARMED && ready_n_o)
    else $error("left acquisition without trigger");
  ext_start_a: assert property (sync_mode && trig_rise && !wr_evt &&
    (state_q == acs_pkg::ACS_ST_ARMED ||
    (state_q == acs_pkg::ACS_ST_IDLE && start_held))
    |=> state_q == acs_pkg::ACS_ST_CONV ##(CONV_CYC) !ready_n_o)
    else $error("trigger did not run conversion");
  abort_a: assert property (wr_evt && wcmd == `ACS_CMD_ABORT |=>
    !ready_n_o [*2])
    else $error("abort did not drop ready");
  stby_exit_a: assert property (state_q == acs_pkg::ACS_ST_STBY &&
    wr_evt && wcmd == `ACS_CMD_START |=> !ready_n_o)
    else $error("start did not leave standby");
  rst_width_a: assert property ($past(rst_i) |-> !bw && ready_n_o)
    else $error("reset state wrong");

  self_conv_c: cover property (state_q == acs_pkg::ACS_ST_ACQ ##1
    state_q == acs_pkg::ACS_ST_CONV);
  ext_conv_c: cover property (state_q == acs_pkg::ACS_ST_ARMED ##1
    state_q == acs_pkg::ACS_ST_CONV);
  cal_c: cover property (state_q == acs_pkg::ACS_ST_CAL ##1
    state_q == acs_pkg::ACS_ST_IDLE);
  abort_c: cover property (state_q == acs_pkg::ACS_ST_CONV && wr_evt &&
    wcmd == `ACS_CMD_ABORT);
endmodule
`default_nettype wire

// File: verification/acs_host.sv
// Host processor model on the converter bus and trigger pin
`timescale 1ns/1ps
`default_nettype none
module acs_host (
  input wire logic clk_i, // Converter clock
  input wire logic [12:0] bus_i, // Resolved data bus
  output logic cs_n_o, // Chip select, low
  output logic rd_n_o, // Read strobe, low
  output logic wr_n_o, // Write strobe, low
  output logic [12:0] data_o, // Data driven by host
  output logic trig_o // Trigger level from host
);
  logic [12:0] last;
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_o = 13'h0000;
    trig_o = 1'b0;
    last = 13'h0000;
  end
  // Every pin level is held long enough for the synchroniser
  task automatic hold();
    repeat (6) @(negedge clk_i);
  endtask
  // Data stays valid around both strobe edges, then goes stale
  task automatic wr_press(input logic [7:0] cfg);
    @(negedge clk_i);
    data_o = {5'h00, cfg};
    last = {5'h00, cfg};
    cs_n_o = 1'b0;
    hold();
    wr_n_o = 1'b0;
    hold();
  endtask
  // Second half of a write, from the strobe release on
  task automatic wr_release();
    wr_n_o = 1'b1;
    hold();
    cs_n_o = 1'b1;
    data_o = ~last;
  endtask
  task automatic write(input logic [7:0] cfg);
    wr_press(cfg);
    wr_release();
  endtask
  // Returns at the strobe release so the caller sees what follows
  task automatic read(output logic [12:0] q);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    hold();
    rd_n_o = 1'b0;
    hold();
    q = bus_i;
    rd_n_o = 1'b1;
  endtask
  task automatic trig(input logic v);
    @(negedge clk_i);
    trig_o = v;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench of the command and conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int CONV = 4;
  localparam int CAL = 20;
  localparam int ZERO = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic strap = 1'b1;
  logic [12:0] result_i = 13'h1a5c;
  wire logic cs_n, rd_n, wr_n, h_trig, data_oe_o, trig_o, trig_oe_o;
  wire logic ready_n_o;
  wire logic [12:0] h_data, data_o, bus;
  wire logic trig_pin;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int rdy_n = 0, rdy_len = 0, trg_n = 0, trg_len = 0, acq_len = 0;
  int acq[4] = '{9, 15, 47, 79};
  logic [12:0] q;
  assign bus = data_oe_o ? data_o : h_data;
  assign trig_pin = trig_oe_o ? trig_o : h_trig;
  always #5 clk_i = ~clk_i;
  acs_host host (.clk_i(clk_i), .bus_i(bus), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .data_o(h_data), .trig_o(h_trig));
  acs_seq #(.CONV_CYC(CONV), .CAL_CYC(CAL), .ZERO_CYC(ZERO)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .write_edge_strap_i(strap), .data_i(bus),
    .data_o(data_o), .data_oe_o(data_oe_o), .trig_i(trig_pin),
    .trig_o(trig_o), .trig_oe_o(trig_oe_o), .ready_n_o(ready_n_o),
    .result_i(result_i));
  // Lengths of the last busy, converting and acquiring runs
  always @(negedge clk_i) begin
    if (trig_o === 1'b1 && trg_n == 0) acq_len = rdy_n;
    if (ready_n_o === 1'b1) rdy_n++;
    else if (rdy_n != 0) begin
      rdy_len = rdy_n;
      rdy_n = 0;
    end
    if (trig_o === 1'b1) trg_n++;
    else if (trg_n != 0) begin
      trg_len = trg_n;
      trg_n = 0;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy(input logic v);
    int n;
    n = 0;
    while (ready_n_o !== v && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    check({15'h0000, ready_n_o}, {15'h0000, v});
  endtask
  task automatic results();
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic s_cal();
    host.write(8'h40);
    wait_rdy(1'b0);
    rdy_len = 0;
    host.write(8'h20);
    wait_rdy(1'b0);
    check(16'(rdy_len), 16'(CAL));
    rdy_len = 0;
    host.write(8'h30);
    wait_rdy(1'b0);
    check(16'(rdy_len), 16'(ZERO));
  endtask
  task automatic s_self8();
    for (int i = 0; i < 4; i++) begin
      host.write(8'h10 | 8'(i));
      check({15'h0000, trig_oe_o}, 16'h0001);
      host.read(q);
      host.read(q);
      wait_rdy(1'b1);
      wait_rdy(1'b0);
      check(16'(acq_len), 16'(acq[i]));
      check(16'(trg_len), 16'(CONV));
      check(16'(rdy_len), 16'(acq[i] + CONV));
      host.read(q);
      check({3'h0, q}, 16'h005c);
      host.read(q);
      check({3'h0, q}, 16'h00fa);
      wait_rdy(1'b1);
      host.write(8'h40);
      wait_rdy(1'b0);
    end
  endtask
  task automatic s_self13();
    result_i = 13'h0a31;
    host.write(8'h18);
    host.read(q);
    wait_rdy(1'b1);
    wait_rdy(1'b0);
    check(16'(acq_len), 16'h0009);
    host.read(q);
    check({3'h0, q}, 16'h0a31);
    wait_rdy(1'b1);
    host.write(8'h40);
    wait_rdy(1'b0);
  endtask
  task automatic s_ext();
    host.write(8'h17);
    check({15'h0000, trig_oe_o}, 16'h0000);
    rdy_len = 0;
    host.trig(1'b1);
    wait_rdy(1'b1);
    wait_rdy(1'b0);
    check(16'(rdy_len), 16'(CONV));
    host.trig(1'b0);
    host.read(q);
    check({3'h0, q}, 16'h0031);
    host.read(q);
    check({3'h0, q}, 16'h000a);
    wait_rdy(1'b1);
    repeat (30) @(negedge clk_i);
    check({15'h0000, ready_n_o}, 16'h0001);
    result_i = 13'h1f0e;
    host.trig(1'b1);
    wait_rdy(1'b0);
    host.trig(1'b0);
    host.write(8'h1c);
    host.read(q);
    wait_rdy(1'b1);
    host.trig(1'b1);
    wait_rdy(1'b0);
    host.trig(1'b0);
    host.read(q);
    check({3'h0, q}, 16'h1f0e);
  endtask
  task automatic s_stby();
    strap = 1'b0;
    host.write(8'h48);
    wait_rdy(1'b0);
    host.wr_press(8'h58);
    check({15'h0000, ready_n_o}, 16'h0000);
    host.wr_release();
    wait_rdy(1'b1);
    host.write(8'h48);
    wait_rdy(1'b0);
    host.write(8'h50);
    wait_rdy(1'b1);
    host.write(8'h10);
    wait_rdy(1'b0);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      results();
    end
  end
  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    check({15'h0000, ready_n_o}, 16'h0001);
    check({15'h0000, trig_oe_o}, 16'h0000);
    s_cal();
    s_self8();
    s_self13();
    s_ext();
    s_stby();
    results();
  end
endmodule
`default_nettype wire
